/* File: rtl/nbm_host.sv */
// nand host sequencer: scan, read, program, erase with bad-block handling
// assumes the device drives ready_busy_n and dq_i asynchronously
`timescale 1ns/1ns
module nbm_host
   import nbm_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // request
   input  wire logic        req_valid,
   input  wire nbm_req_s    req,
   output      logic        req_ready,
   // write data stream
   input  wire logic [7:0]  wr_data,
   output      logic        wr_take,
   // read data stream
   output      logic [7:0]  rd_data,
   output      logic        rd_valid,
   // completion
   output      logic        done,
   output      logic        failed,
   output      logic        refused,
   output      logic        scan_done,
   // device pins
   output      nbm_pins_s   pins,
   input  wire logic [7:0]  dq_i,
   input  wire logic        ready_busy_n
);
   typedef enum logic [3:0] {
      S_RST, S_RST_WAIT, S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_WAIT,
      S_DATA_W, S_DATA_R, S_STAT_CMD, S_STAT_RD, S_FINISH
   } nbm_st_e;

   nbm_st_e     st_r, st_nxt;
   nbm_req_s    cur_r, cur_nxt;
   logic [2:0]  acnt_r, acnt_nxt;
   logic [11:0] bcnt_r, bcnt_nxt;
   logic [10:0] tim_r, tim_nxt;
   logic        ph_r, ph_nxt;
   logic [10:0] scan_blk_r, scan_blk_nxt;
   logic        scan_pg_r, scan_pg_nxt;
   logic        scanning_r, scanning_nxt;
   logic [6:0]  last_pg_r [2], last_pg_nxt [2];
   logic [10:0] last_blk_r, last_blk_nxt;
   logic        ok_r, ok_nxt;
   logic [7:0]  rdat_r, rdat_nxt;
   logic        rval_r, rval_nxt, done_r, done_nxt, fail_r, fail_nxt;
   logic        ref_r, ref_nxt, sdone_r, sdone_nxt;
   nbm_pins_s   pins_r, pins_nxt;
   logic [7:0]  dq_s1, dq_s2;
   logic        rb_s1, rb_s2;
   logic        mark;
   logic        look_bad;
   logic [7:0]  cmd_a, cmd_b, abyte;

   always_ff @(posedge clk) begin
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
      rb_s1 <= ready_busy_n;
      rb_s2 <= rb_s1;
   end

   nbm_bad_table i_nbm_bad_table (
      .clk      (clk),
      .reset    (reset),
      .mark     (mark),
      .mark_blk (cur_r.block),
      .look_blk (req.block),
      .look_bad (look_bad)
   );

   always_comb begin
      // plain page reads only: no cache read, no 31 or 3F end
      unique case (cur_r.op)
         NBM_OP_PROG:  begin cmd_a = CMD_PROG0;  cmd_b = CMD_PROG1;  end
         NBM_OP_ERASE: begin cmd_a = CMD_ERASE0; cmd_b = CMD_ERASE1; end
         default:      begin cmd_a = CMD_READ0;  cmd_b = CMD_READ1;  end
      endcase
      // erase sends only the three row bytes
      unique case (acnt_r + ((cur_r.op == NBM_OP_ERASE) ? 3'd2 : 3'd0))
         3'd0:    abyte = cur_r.col[7:0];
         3'd1:    abyte = {4'h0, cur_r.col[11:8]};
         3'd2:    abyte = {cur_r.block[1:0], cur_r.page};
         3'd3:    abyte = cur_r.block[9:2];
         default: abyte = {7'h00, cur_r.block[10]};
      endcase
   end

   // each pin byte is two phases: strobe low, then strobe high
   always_comb begin
      st_nxt = st_r; cur_nxt = cur_r; acnt_nxt = acnt_r; bcnt_nxt = bcnt_r;
      tim_nxt = tim_r; ph_nxt = ph_r; scan_blk_nxt = scan_blk_r;
      scan_pg_nxt = scan_pg_r; scanning_nxt = scanning_r;
      last_pg_nxt = last_pg_r; last_blk_nxt = last_blk_r; ok_nxt = ok_r;
      rdat_nxt = rdat_r; rval_nxt = 1'b0; done_nxt = 1'b0; fail_nxt = 1'b0;
      ref_nxt = 1'b0; sdone_nxt = 1'b0; pins_nxt = pins_r;
      mark = 1'b0; wr_take = 1'b0; req_ready = 1'b0;
      pins_nxt.cle = 1'b0; pins_nxt.ale = 1'b0;
      pins_nxt.we_n = 1'b1; pins_nxt.read_strobe_n = 1'b1;
      pins_nxt.dq_oe = 1'b0; pins_nxt.ce_n = 1'b0;
      if (tim_r != 11'd0) begin
         tim_nxt = tim_r - 11'd1;
         pins_nxt = pins_r;
      end else begin
         tim_nxt = 11'(PHASE_CYC - 1);
         ph_nxt = ~ph_r;
         unique case (st_r)
            S_RST: begin
               pins_nxt.cle = 1'b1; pins_nxt.dq_oe = 1'b1;
               pins_nxt.we_n = ph_r; pins_nxt.dq_o = CMD_RESET;
               if (ph_r) begin
                  st_nxt = S_RST_WAIT;
                  tim_nxt = 11'(RST_CYC);
               end
            end
            S_RST_WAIT: begin
               ph_nxt = 1'b0;
               if (rb_s2) st_nxt = S_IDLE;
            end
            S_IDLE: begin
               ph_nxt = 1'b0; pins_nxt.ce_n = 1'b1;
               acnt_nxt = '0; bcnt_nxt = '0; ok_nxt = 1'b1;
               if (scanning_r) begin
                  cur_nxt = '{NBM_OP_SCAN, scan_blk_r,
                              {5'd0, scan_pg_r}, SPARE_COL};
                  st_nxt = S_CMD1;
               end else if (req_valid) begin
                  req_ready = 1'b1;
                  cur_nxt = req;
                  // program or erase to a bad block, and program at or below the last page, are refused
                  if ((req.op == NBM_OP_PROG || req.op == NBM_OP_ERASE)
                      && look_bad) begin
                     ref_nxt = 1'b1;
                  end else if (req.op == NBM_OP_PROG
                      && req.block == last_blk_r
                      && {1'b0, req.page} <= last_pg_r[0]
                      && last_pg_r[1][0]) begin
                     ref_nxt = 1'b1;
                  end else if (req.op == NBM_OP_SCAN) begin
                     scanning_nxt = 1'b1;
                     scan_blk_nxt = '0; scan_pg_nxt = 1'b0;
                  end else begin
                     st_nxt = S_CMD1;
                  end
               end
            end
            S_CMD1: begin
               pins_nxt.cle = 1'b1; pins_nxt.dq_oe = 1'b1;
               pins_nxt.we_n = ph_r; pins_nxt.dq_o = cmd_a;
               if (ph_r) st_nxt = S_ADDR;
            end
            S_ADDR: begin
               pins_nxt.ale = 1'b1; pins_nxt.dq_oe = 1'b1;
               pins_nxt.we_n = ph_r; pins_nxt.dq_o = abyte;
               if (ph_r) begin
                  acnt_nxt = acnt_r + 3'd1;
                  if (acnt_r == 3'((cur_r.op == NBM_OP_ERASE)
                                   ? ADDR_CYCLES - 3 : ADDR_CYCLES - 1)) begin
                     st_nxt = (cur_r.op == NBM_OP_PROG) ? S_DATA_W : S_CMD2;
                     tim_nxt = 11'(ADL_CYC);
                  end
               end
            end
            S_DATA_W: begin
               pins_nxt.dq_oe = 1'b1; pins_nxt.we_n = ph_r;
               if (!ph_r) begin
                  pins_nxt.dq_o = wr_data;
                  wr_take = 1'b1;
               end else begin
                  bcnt_nxt = bcnt_r + 12'd1;
                  if (bcnt_r == 12'(PAGE_BYTES - 1)) st_nxt = S_CMD2;
               end
            end
            S_CMD2: begin
               pins_nxt.cle = 1'b1; pins_nxt.dq_oe = 1'b1;
               pins_nxt.we_n = ph_r; pins_nxt.dq_o = cmd_b;
               if (ph_r) begin
                  st_nxt = S_WAIT;
                  tim_nxt = 11'(ADL_CYC);
               end
            end
            S_WAIT: begin
               ph_nxt = 1'b0;
               if (rb_s2) begin
                  st_nxt = (cur_r.op == NBM_OP_PROG
                            || cur_r.op == NBM_OP_ERASE)
                           ? S_STAT_CMD : S_DATA_R;
               end
            end
            S_DATA_R: begin
               pins_nxt.read_strobe_n = ph_r;
               if (ph_r) begin
                  bcnt_nxt = bcnt_r + 12'd1;
                  if (cur_r.op == NBM_OP_SCAN) begin
                     ok_nxt = (dq_s2 == ERASED_BYTE);
                     st_nxt = S_FINISH;
                  end else begin
                     rdat_nxt = dq_s2;
                     rval_nxt = 1'b1;
                     if (bcnt_r == 12'(PAGE_BYTES - 1) - cur_r.col)
                        st_nxt = S_FINISH;
                  end
               end
            end
            S_STAT_CMD: begin
               pins_nxt.cle = 1'b1; pins_nxt.dq_oe = 1'b1;
               pins_nxt.we_n = ph_r; pins_nxt.dq_o = CMD_STATUS;
               if (ph_r) st_nxt = S_STAT_RD;
            end
            S_STAT_RD: begin
               pins_nxt.read_strobe_n = ph_r;
               if (ph_r) begin
                  ok_nxt = ~dq_s2[ST_FAIL_BIT];
                  st_nxt = S_FINISH;
               end
            end
            S_FINISH: begin
               ph_nxt = 1'b0;
               st_nxt = S_IDLE;
               if (!ok_r) mark = 1'b1;
               if (cur_r.op == NBM_OP_SCAN) begin
                  scan_pg_nxt = ~scan_pg_r;
                  if (scan_pg_r) begin
                     scan_blk_nxt = scan_blk_r + 11'd1;
                     if (scan_blk_r == 11'(NUM_BLOCKS - 1)) begin
                        scanning_nxt = 1'b0;
                        sdone_nxt = 1'b1;
                     end
                  end
               end else begin
                  done_nxt = 1'b1;
                  fail_nxt = ~ok_r;
                  if (cur_r.op == NBM_OP_PROG) begin
                     last_blk_nxt = cur_r.block;
                     last_pg_nxt[0] = {1'b0, cur_r.page};
                     last_pg_nxt[1] = 7'd1;
                  end else if (cur_r.op == NBM_OP_ERASE
                               && cur_r.block == last_blk_r) begin
                     last_pg_nxt[1] = 7'd0;
                  end
               end
            end
            default: st_nxt = S_RST;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_r <= S_RST; cur_r <= '0; acnt_r <= '0; bcnt_r <= '0;
         tim_r <= '0; ph_r <= 1'b0; scan_blk_r <= '0; scan_pg_r <= 1'b0;
         scanning_r <= 1'b0; last_pg_r[0] <= '0; last_pg_r[1] <= '0;
         last_blk_r <= '0; ok_r <= 1'b1; rdat_r <= '0; rval_r <= 1'b0;
         done_r <= 1'b0; fail_r <= 1'b0; ref_r <= 1'b0; sdone_r <= 1'b0;
         pins_r <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 1'b0};
      end else begin
         st_r <= st_nxt; cur_r <= cur_nxt; acnt_r <= acnt_nxt;
         bcnt_r <= bcnt_nxt; tim_r <= tim_nxt; ph_r <= ph_nxt;
         scan_blk_r <= scan_blk_nxt; scan_pg_r <= scan_pg_nxt;
         scanning_r <= scanning_nxt; last_pg_r <= last_pg_nxt;
         last_blk_r <= last_blk_nxt; ok_r <= ok_nxt; rdat_r <= rdat_nxt;
         rval_r <= rval_nxt; done_r <= done_nxt; fail_r <= fail_nxt;
         ref_r <= ref_nxt; sdone_r <= sdone_nxt; pins_r <= pins_nxt;
      end
   end

   assign pins      = pins_r;
   assign rd_data   = rdat_r; // uncorrected; ecc is the reader's job
   assign rd_valid  = rval_r;
   assign done      = done_r;
   assign failed    = fail_r;
   assign refused   = ref_r;
   assign scan_done = sdone_r;

   ////////////////////////////////////////////////////////////////////////
   a_refuse_bad: assert property (@(posedge clk) disable iff (reset)
      req_ready && look_bad && req.op == NBM_OP_ERASE |=> refused)
      else $error("erase to bad block not refused");
   a_addr_count: assert property (@(posedge clk) disable iff (reset)
      st_r == S_ADDR && cur_r.op == NBM_OP_READ |-> acnt_r < 3'd5)
      else $error("more than five address bytes");
   a_fail_mark: assert property (@(posedge clk) disable iff (reset)
      st_r == S_FINISH && !ok_r && tim_r == 11'd0 |-> mark)
      else $error("failed block not marked");
   a_scan_col: assert property (@(posedge clk) disable iff (reset)
      st_r == S_ADDR && cur_r.op == NBM_OP_SCAN
      |-> cur_r.col == SPARE_COL && cur_r.page[5:1] == 5'd0)
      else $error("scan outside spare byte of pages 0 and 1");
   a_prog_order: assert property (@(posedge clk) disable iff (reset)
      req_ready && req.op == NBM_OP_PROG && req.block == last_blk_r
      && last_pg_r[1][0] && {1'b0, req.page} <= last_pg_r[0] |=> refused)
      else $error("program at or below last page not refused");
   a_read_keep: assert property (@(posedge clk) disable iff (reset)
      st_r == S_FINISH && cur_r.op == NBM_OP_READ |-> !mark)
      else $error("plain read retired a block");
endmodule : nbm_host

/* File: rtl/nbm_pkg.sv */
// package: constants and carrier types for the nand block manager host
// assumes one 250 MHz clock and a multiplexed x8 nand device on pins
package nbm_pkg;
   localparam int          CLK_MHZ       = 250;
   localparam logic [7:0]  CMD_READ0     = 8'h00;
   localparam logic [7:0]  CMD_READ1     = 8'h30;
   localparam logic [7:0]  CMD_PROG0     = 8'h80;
   localparam logic [7:0]  CMD_PROG1     = 8'h10;
   localparam logic [7:0]  CMD_ERASE0    = 8'h60;
   localparam logic [7:0]  CMD_ERASE1    = 8'hD0;
   localparam logic [7:0]  CMD_STATUS    = 8'h70;
   localparam logic [7:0]  CMD_RESET     = 8'hFF;
   localparam logic [7:0]  CMD_CACHE_END = 8'h3F;
   localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
   localparam int          ST_FAIL_BIT   = 0;
   localparam int          ST_READY_BIT  = 6;
   localparam logic [11:0] SPARE_COL     = 12'h800;
   localparam int          PAGE_BYTES    = 2112;
   localparam int          NUM_BLOCKS    = 2048;
   localparam int          PAGES_PER_BLK = 64;
   localparam int          ADDR_CYCLES   = 5;
   // pin phase length: 40 ns write or read cycle split into halves
   localparam int          PHASE_NS      = 20;
   localparam int          PHASE_CYC     = (PHASE_NS * CLK_MHZ + 999) / 1000;
   localparam int          ADL_NS        = 100;
   localparam int          ADL_CYC       = (ADL_NS * CLK_MHZ + 999) / 1000;
   localparam int          RST_US        = 5;
   localparam int          RST_CYC       = RST_US * CLK_MHZ;

   typedef enum logic [1:0] {
      NBM_OP_SCAN, NBM_OP_READ, NBM_OP_PROG, NBM_OP_ERASE
   } nbm_op_e;

   typedef struct packed {
      nbm_op_e     op;
      logic [10:0] block;
      logic [5:0]  page;
      logic [11:0] col;
   } nbm_req_s;

   typedef struct packed {
      logic       ce_n;
      logic       cle;
      logic       ale;
      logic       we_n;
      logic       read_strobe_n;
      logic [7:0] dq_o;
      logic       dq_oe;
   } nbm_pins_s;
endpackage : nbm_pkg

/* File: rtl/nbm_bad_table.sv */
// bad block table: one flag per block, flip-flop storage
// assumes set and lookup come from the sequencer on the same clock
`timescale 1ns/1ns
module nbm_bad_table
   import nbm_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // marking
   input  wire logic        mark,
   input  wire logic [10:0] mark_blk,
   // lookup
   input  wire logic [10:0] look_blk,
   output      logic        look_bad
);
   logic [NUM_BLOCKS-1:0] bad_r;
   logic [NUM_BLOCKS-1:0] bad_nxt;

   genvar g;
   generate
      for (g = 0; g < NUM_BLOCKS; g++) begin : g_ent
         always_comb begin
            bad_nxt[g] = bad_r[g] | (mark && mark_blk == 11'(g));
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (reset) begin
         bad_r <= '0;
      end else begin
         bad_r <= bad_nxt;
      end
   end

   assign look_bad = bad_r[look_blk] | (mark && mark_blk == look_blk);
endmodule : nbm_bad_table

/* File: tb/nbm_flash_model.sv */
// flash model: one x8 nand die answering the host pins, behavioural
// assumes pins come registered from the host; busy time set by the bench, except the fixed 1000 ns after reset
`timescale 1ns/1ns
module nbm_flash_model
   import nbm_pkg::*;
#(
   // block carrying the factory mark; value is arbitrary
   parameter logic [10:0] FACT_BLK = 11'h014
)
(
   // host pins
   input  wire nbm_pins_s   pins,
   output      logic [7:0]  dq_i,
   output      logic        ready_busy_n,
   // scenario knobs and probes
   input  wire logic [10:0] fail_blk,
   input  wire logic [15:0] busy_ns,
   output      logic [16:0] last_row,
   output      logic [11:0] last_col
);
   logic [7:0]  mem [logic [28:0]];
   logic [7:0]  pbuf [logic [11:0]];
   logic [7:0]  cmd;
   logic [7:0]  stat;
   logic [7:0]  ab [5];
   int          acnt;
   logic [11:0] col;
   logic        fail;
   logic [28:0] dk [$];

   initial begin
      dq_i = 8'hA5;
      ready_busy_n = 1'b1;
      stat = 8'h40;
      cmd = 8'h00;
      acnt = 0;
      col = '0;
   end

   task automatic go_busy(input int ns, input logic f);
      ready_busy_n = 1'b0;
      stat = 8'h00;
      #(ns);
      stat = {1'b0, 1'b1, 5'h00, f};
      ready_busy_n = 1'b1;
   endtask : go_busy

   ////////////////////////////////////////////////////////////////////////
   always @(posedge pins.we_n) begin
      if (!pins.ce_n && pins.cle) begin
         cmd = pins.dq_o;
         case (pins.dq_o)
            CMD_READ0, CMD_PROG0, CMD_ERASE0: acnt = 0;
            CMD_READ1: go_busy(busy_ns, 1'b0);
            CMD_PROG1: begin
               fail = (last_row[16:6] == fail_blk);
               // failed page leaves the rest of the block alone
               if (!fail) foreach (pbuf[c]) mem[{last_row, c}] = pbuf[c];
               pbuf.delete();
               go_busy(busy_ns, fail);
            end
            CMD_ERASE1: begin
               fail = (last_row[16:6] == fail_blk);
               dk = {};
               foreach (mem[k]) if (!fail && k[28:18] == last_row[16:6])
                  dk.push_back(k);
               foreach (dk[i]) mem.delete(dk[i]);
               go_busy(busy_ns, fail);
            end
            CMD_CACHE_END: col = '0;
            CMD_RESET: go_busy(1000, 1'b0);
            default: ;
         endcase
      end else if (!pins.ce_n && pins.ale) begin
         // erase carries row bytes only, so they land in slots 2..4
         ab[(cmd == CMD_ERASE0) ? acnt + 2 : acnt] = pins.dq_o;
         acnt++;
         col = {ab[1][3:0], ab[0]};
         last_col = col;
         last_row = {ab[4][0], ab[3], ab[2]};
      end else if (!pins.ce_n && cmd == CMD_PROG0) begin
         pbuf[col] = pins.dq_o;
         col++;
      end
   end

   always @(negedge pins.read_strobe_n) begin
      if (!pins.ce_n && cmd == CMD_STATUS) begin
         dq_i = stat;
      end else if (!pins.ce_n) begin
         if (mem.exists({last_row, col}))
            dq_i = mem[{last_row, col}];
         else if (last_row[16:6] == FACT_BLK && last_row[5:1] == 5'h00
                  && col == SPARE_COL)
            dq_i = 8'h00;
         else
            dq_i = ERASED_BYTE;
         col++;
      end
   end

   // data held a short while after the strobe rises, then not valid
   always @(posedge pins.read_strobe_n) begin
      #15;
      if (pins.read_strobe_n) dq_i = ~dq_i;
   end
endmodule : nbm_flash_model

/* File: tb/nbm_host_bench.sv */
// bench: directed scenarios for the nand host sequencer
// assumes the flash model stands on the pins, one 250 MHz clock
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end
module nbm_host_bench;
   import nbm_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        req_valid = 1'b0;
   nbm_req_s    req = '0;
   logic [7:0]  wr_data, rd_data, dq_i;
   logic        wr_take, rd_valid, done, failed, refused, scan_done;
   logic        req_ready, ready_busy_n;
   nbm_pins_s   pins;
   logic [10:0] fail_blk = 11'h009;
   logic [15:0] busy_ns = 16'h00C8;
   logic [16:0] last_row;
   logic [11:0] last_col;
   int          errors = 0, checked = 0, cyc = 0, wr_idx = 0, base;
   logic [7:0]  rd_q [$];
   logic [2:0]  res;

   always #2 clk = ~clk;
   assign wr_data = 8'(wr_idx) ^ 8'h5A;
   always @(posedge clk) begin
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      if (wr_take === 1'b1) wr_idx <= wr_idx + 1;
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         errors++;
         print_verdict();
      end
   end

   nbm_host i_nbm_host (.clk(clk), .reset(reset), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .wr_data(wr_data),
      .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
      .done(done), .failed(failed), .refused(refused),
      .scan_done(scan_done), .pins(pins), .dq_i(dq_i),
      .ready_busy_n(ready_busy_n));
   nbm_flash_model i_nbm_flash_model (.pins(pins), .dq_i(dq_i),
      .ready_busy_n(ready_busy_n), .fail_blk(fail_blk), .busy_ns(busy_ns),
      .last_row(last_row), .last_col(last_col));

   ////////////////////////////////////////////////////////////////////////
   // a hang is caught by the cycle watchdog, which ends the run
   task automatic take_req(input nbm_op_e op, input logic [10:0] blk,
                           input logic [5:0] pg, input logic [11:0] col);
      rd_q.delete();
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{op: op, block: blk, page: pg, col: col};
      do @(negedge clk); while (req_ready !== 1'b1);
      @(posedge clk);
      req_valid <= 1'b0;
   endtask : take_req

   task automatic run_op(input nbm_op_e op, input logic [10:0] blk,
                         input logic [5:0] pg, input logic [11:0] col);
      take_req(op, blk, pg, col);
      do @(negedge clk); while (done !== 1'b1 && refused !== 1'b1);
      res = {done, failed, refused};
   endtask : run_op

   task automatic t_erased_read;
      run_op(NBM_OP_READ, 11'h007, 6'h02, 12'h83C);
      `CHK(res, 3'b100)
      `CHK(last_col, 12'h83C)
      `CHK(last_row, {11'h007, 6'h02})
      `CHK(rd_q.size(), 4)
      foreach (rd_q[i]) `CHK(rd_q[i], ERASED_BYTE)
      $display("test erased_read done");
   endtask : t_erased_read

   task automatic t_factory_mark;
      run_op(NBM_OP_READ, 11'h014, 6'h01, SPARE_COL);
      `CHK(res, 3'b100)
      `CHK(rd_q.size(), 64)
      `CHK(rd_q[0], 8'h00)
      `CHK(rd_q[1], ERASED_BYTE)
      $display("test factory_mark done");
   endtask : t_factory_mark

   task automatic t_prog_order;
      base = wr_idx;
      run_op(NBM_OP_PROG, 11'h003, 6'h05, 12'h000);
      `CHK(res, 3'b100)
      `CHK(wr_idx - base, PAGE_BYTES)
      run_op(NBM_OP_PROG, 11'h003, 6'h04, 12'h000);
      `CHK(res, 3'b001)
      run_op(NBM_OP_PROG, 11'h003, 6'h05, 12'h000);
      `CHK(res, 3'b001)
      `CHK(wr_idx - base, PAGE_BYTES)
      // slow array fetch this time
      busy_ns = 16'h07D0;
      run_op(NBM_OP_READ, 11'h003, 6'h05, 12'h83C);
      `CHK(rd_q.size(), 4)
      foreach (rd_q[i]) `CHK(rd_q[i], 8'(base + 2108 + i) ^ 8'h5A)
      $display("test prog_order done");
   endtask : t_prog_order

   task automatic t_retire;
      run_op(NBM_OP_ERASE, 11'h009, 6'h00, 12'h000);
      `CHK(res, 3'b110)
      run_op(NBM_OP_PROG, 11'h009, 6'h00, 12'h000);
      `CHK(res, 3'b001)
      run_op(NBM_OP_ERASE, 11'h009, 6'h00, 12'h000);
      `CHK(res, 3'b001)
      busy_ns = 16'h00C8;
      run_op(NBM_OP_ERASE, 11'h003, 6'h00, 12'h000);
      `CHK(res, 3'b100)
      run_op(NBM_OP_READ, 11'h003, 6'h05, 12'h83E);
      foreach (rd_q[i]) `CHK(rd_q[i], ERASED_BYTE)
      `CHK(rd_q.size(), 2)
      $display("test retire done");
   endtask : t_retire

   // full scan outlasts the run: stop it by reset past the marked block
   task automatic t_scan_reset;
      take_req(NBM_OP_SCAN, 11'h000, 6'h00, 12'h000);
      do @(negedge clk); while (last_row[16:6] !== 11'h015);
      `CHK(last_col, SPARE_COL)
      `CHK(last_row, {11'h015, 6'h00})
      `CHK(scan_done, 1'b0)
      `CHK(i_nbm_host.i_nbm_bad_table.bad_r[20], 1'b1)
      `CHK(i_nbm_host.i_nbm_bad_table.bad_r[19], 1'b0)
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      `CHK({pins.ce_n, pins.we_n, pins.dq_oe}, 3'b110)
      run_op(NBM_OP_READ, 11'h013, 6'h00, 12'h83F);
      `CHK(res, 3'b100)
      `CHK(rd_q.size(), 1)
      `CHK(rd_q[0], ERASED_BYTE)
      $display("test scan_reset done");
   endtask : t_scan_reset

   task automatic print_verdict;
      $display("checks made %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_erased_read();
      t_factory_mark();
      t_prog_order();
      t_retire();
      t_scan_reset();
      print_verdict();
   end
endmodule : nbm_host_bench
